/* src/cic_pkg.sv */
// Shared constants and carrier types for the cascaded interrupt controller.
package cic_pkg;

	// I/O port addresses of the two controllers.
	localparam logic [15:0] MASTER_EVEN = 16'h0020;
	localparam logic [15:0] MASTER_ODD = 16'h0021;
	localparam logic [15:0] SLAVE_EVEN = 16'h00A0;
	localparam logic [15:0] SLAVE_ODD = 16'h00A1;

	// Field positions in init_word_one, plus the read-back select bit of a command word.
	localparam int IW1_NEED_W4 = 0;
	localparam int IW1_SINGLE = 1;
	localparam int IW1_LEVEL = 3;
	localparam int CMD_INIT = 4;
	localparam int CMD_READBACK = 3;

	// Field positions in mode_option_word.
	localparam int IW4_AEOI_OFF = 1;
	localparam int IW4_NESTED = 4;

	// Field positions in readback_poll_command.
	localparam int RB_POLL = 2;

	// Slave identity and cascade line after initialization starts.
	localparam logic [2:0] SLAVE_ADDR_RST = 3'h7;
	// Lowest-priority line after init starts; the scan then ranks line 7 first.
	localparam logic [2:0] PRIO_LOW_RST = 3'h6;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// Commands carried in bits 7 to 5 of eoi_rotate_command.
	localparam logic [2:0] OP_CLR_AEOI_ROT = 3'h0;
	localparam logic [2:0] OP_NS_EOI = 3'h1;
	localparam logic [2:0] OP_NOP = 3'h2;
	localparam logic [2:0] OP_SP_EOI = 3'h3;
	localparam logic [2:0] OP_SET_AEOI_ROT = 3'h4;
	localparam logic [2:0] OP_ROT_NS_EOI = 3'h5;
	localparam logic [2:0] OP_SET_PRIO = 3'h6;
	localparam logic [2:0] OP_ROT_SP_EOI = 3'h7;

	// Read-back selections in bits 1 and 0 of readback_poll_command.
	localparam logic [1:0] RB_READ_REQ = 2'h2;
	localparam logic [1:0] RB_READ_ISR = 2'h3;
	// Special mask selections in bits 6 and 5 of readback_poll_command.
	localparam logic [1:0] SMM_OFF = 2'h2;
	localparam logic [1:0] SMM_ON = 2'h3;

	// Poll answer: bit 7 flags a pending request, low bits name it.
	localparam int POLL_HIT = 7;

	typedef enum logic [1:0] {
		CIC_ST_RUN,
		CIC_ST_W2,
		CIC_ST_W3,
		CIC_ST_W4
	} cic_init_t;

	// One byte-wide I/O access addressed to a controller.
	typedef struct packed {
		logic wr;
		logic rd;
		logic odd;
		logic [7:0] data;
	} cic_io_t;

	// Configuration latched from the initialization words.
	typedef struct packed {
		logic need_w4;
		logic single;
		logic level;
		logic [4:0] vec_hi;
		logic [7:0] cascade;
		logic aeoi;
		logic nested;
	} cic_cfg_t;

endpackage

/* src/cic_prio.sv */
// Rotating priority resolver: picks the highest-priority set bit.
`timescale 1ns/100ps
`default_nettype none
module cic_prio (
	// Request vector and rotation point
	input wire logic [7:0] req,
	input wire logic [2:0] low_line,
	// Result
	output logic hit,
	output logic [2:0] line
);

	logic [3:0] k;
	logic [2:0] cand;

	// Scan down from the lowest-priority line; the last hit, nearest the line just above it, wins.
	always_comb begin
		hit = 1'b0;
		line = 3'h0;
		cand = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			k = 4'(i);
			cand = low_line + 3'h1 + k[2:0];
			if (req[cand]) begin
				hit = 1'b1;
				line = cand;
			end
		end
	end

endmodule
`default_nettype wire

/* src/cic_unit.sv */
// One controller of the pair: commands, masking, priority and read-back.
`timescale 1ns/100ps
`default_nettype none
module cic_unit (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Host access for this controller
	input wire cic_pkg::cic_io_t io,
	// Synchronised request lines and acknowledge
	input wire logic [7:0] irq,
	input wire logic ack,
	// Outputs
	output logic int_req,
	output logic [7:0] vector,
	output logic [7:0] rd_data,
	output cic_pkg::cic_cfg_t cfg,
	output logic [2:0] slave_id
);

	cic_pkg::cic_init_t st_ff, nxt_st;
	cic_pkg::cic_cfg_t cfg_ff, nxt_cfg;
	logic [7:0] irr_ff, nxt_irr, isr_ff, nxt_isr, imr_ff, nxt_imr;
	logic [7:0] last_ff, nxt_last, vec_ff, nxt_vec, rd_ff, nxt_rd;
	logic [2:0] low_ff, nxt_low, sid_ff, nxt_sid;
	logic smm_ff, nxt_smm, rd_isr_ff, nxt_rd_isr, poll_ff, nxt_poll;
	logic arot_ff, nxt_arot;
	logic [7:0] cand_req, eff_isr;
	logic req_hit, isr_hit, cmd_w, is_init;
	logic [2:0] req_line, isr_line, op, lvl;

	function automatic logic [7:0] bit_of(input logic [2:0] n);
		bit_of = 8'h01 << n;
	endfunction

	// Rank 0 is the line just above the lowest-priority one.
	function automatic logic [2:0] rank_of(input logic [2:0] n,
		input logic [2:0] low);
		rank_of = n - low - 3'h1;
	endfunction

	// In special mask mode masked in-service lines stop blocking others.
	assign eff_isr = smm_ff ? (isr_ff & ~imr_ff) : isr_ff;
	assign cand_req = irr_ff & ~imr_ff;

	cic_prio u_req (
		.req(cand_req),
		.low_line(low_ff),
		.hit(req_hit),
		.line(req_line)
	);

	cic_prio u_isr (
		.req(eff_isr),
		.low_line(low_ff),
		.hit(isr_hit),
		.line(isr_line)
	);

	assign cmd_w = io.wr && !io.odd;
	assign is_init = cmd_w && io.data[cic_pkg::CMD_INIT];
	assign op = io.data[7:5];
	assign lvl = io.data[2:0];

	always_comb begin
		nxt_st = st_ff;
		nxt_cfg = cfg_ff;
		nxt_imr = imr_ff;
		nxt_isr = isr_ff;
		nxt_low = low_ff;
		nxt_sid = sid_ff;
		nxt_smm = smm_ff;
		nxt_rd_isr = rd_isr_ff;
		nxt_poll = poll_ff;
		nxt_arot = arot_ff;
		nxt_vec = vec_ff;
		nxt_rd = rd_ff;
		nxt_last = irq;
		// Edge mode latches rising edges, level mode follows the lines.
		if (cfg_ff.level) begin
			nxt_irr = irq;
		end else begin
			nxt_irr = (irr_ff | (irq & ~last_ff)) & irq;
		end
		if (is_init) begin
			nxt_st = cic_pkg::CIC_ST_W2;
			nxt_cfg.need_w4 = io.data[cic_pkg::IW1_NEED_W4];
			nxt_cfg.single = io.data[cic_pkg::IW1_SINGLE];
			nxt_cfg.level = io.data[cic_pkg::IW1_LEVEL];
			nxt_low = cic_pkg::PRIO_LOW_RST;
			nxt_imr = cic_pkg::BYTE_ZERO;
			nxt_sid = cic_pkg::SLAVE_ADDR_RST;
			nxt_smm = 1'b0;
			nxt_rd_isr = 1'b0;
			nxt_poll = 1'b0;
			nxt_arot = 1'b0;
			nxt_irr = cic_pkg::BYTE_ZERO;
			nxt_isr = cic_pkg::BYTE_ZERO;
			nxt_last = irq;
		end else if (cmd_w) begin
			nxt_st = cic_pkg::CIC_ST_RUN;
			if (io.data[cic_pkg::CMD_READBACK]) begin
				if (io.data[1:0] == cic_pkg::RB_READ_REQ) begin
					nxt_rd_isr = 1'b0;
				end else if (io.data[1:0] == cic_pkg::RB_READ_ISR) begin
					nxt_rd_isr = 1'b1;
				end
				nxt_poll = io.data[cic_pkg::RB_POLL];
				if (io.data[6:5] == cic_pkg::SMM_OFF) begin
					nxt_smm = 1'b0;
				end else if (io.data[6:5] == cic_pkg::SMM_ON) begin
					nxt_smm = 1'b1;
				end
			end else begin
				case (op)
					cic_pkg::OP_NS_EOI: begin
						if (isr_hit) begin
							nxt_isr[isr_line] = 1'b0;
						end
					end
					cic_pkg::OP_ROT_NS_EOI: begin
						if (isr_hit) begin
							nxt_isr[isr_line] = 1'b0;
							nxt_low = isr_line;
						end
					end
					cic_pkg::OP_SP_EOI: begin
						nxt_isr = isr_ff & ~bit_of(lvl);
					end
					cic_pkg::OP_ROT_SP_EOI: begin
						nxt_isr = isr_ff & ~bit_of(lvl);
						nxt_low = lvl;
					end
					cic_pkg::OP_SET_PRIO: begin
						nxt_low = lvl;
					end
					cic_pkg::OP_SET_AEOI_ROT: begin
						nxt_arot = 1'b1;
					end
					cic_pkg::OP_CLR_AEOI_ROT: begin
						nxt_arot = 1'b0;
					end
					default: begin
					end
				endcase
			end
		end else if (io.wr && io.odd) begin
			case (st_ff)
				cic_pkg::CIC_ST_W2: begin
					nxt_cfg.vec_hi = io.data[7:3];
					nxt_st = cfg_ff.single ? (cfg_ff.need_w4 ?
						cic_pkg::CIC_ST_W4 : cic_pkg::CIC_ST_RUN) :
						cic_pkg::CIC_ST_W3;
				end
				cic_pkg::CIC_ST_W3: begin
					nxt_cfg.cascade = io.data;
					nxt_sid = io.data[2:0];
					nxt_st = cfg_ff.need_w4 ? cic_pkg::CIC_ST_W4 :
						cic_pkg::CIC_ST_RUN;
				end
				cic_pkg::CIC_ST_W4: begin
					nxt_cfg.aeoi = !io.data[cic_pkg::IW4_AEOI_OFF];
					nxt_cfg.nested = io.data[cic_pkg::IW4_NESTED];
					nxt_st = cic_pkg::CIC_ST_RUN;
				end
				default: begin
					nxt_imr = io.data;
				end
			endcase
		end
		// Acknowledge or poll read moves the winner into service, or with aeoi set clears its request and, if arot_ff is set, makes it lowest priority.
		if (!is_init && (ack || (io.rd && poll_ff && !io.odd)) && req_hit) begin
			nxt_irr[req_line] = 1'b0;
			nxt_vec = {cfg_ff.vec_hi, req_line};
			if (cfg_ff.aeoi) begin
				if (arot_ff) begin
					nxt_low = req_line;
				end
			end else begin
				nxt_isr[req_line] = 1'b1;
			end
		end
		// Read data are captured so the bus sees a registered byte.
		if (io.odd) begin
			nxt_rd = imr_ff;
		end else if (poll_ff) begin
			nxt_rd = {req_hit, 4'h0, req_line};
		end else begin
			nxt_rd = rd_isr_ff ? isr_ff : irr_ff;
		end
		if (io.rd && poll_ff && !io.odd) begin
			nxt_poll = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_ff <= cic_pkg::CIC_ST_RUN;
			cfg_ff <= '0;
			irr_ff <= cic_pkg::BYTE_ZERO;
			isr_ff <= cic_pkg::BYTE_ZERO;
			imr_ff <= cic_pkg::BYTE_ZERO;
			last_ff <= cic_pkg::BYTE_ZERO;
			vec_ff <= cic_pkg::BYTE_ZERO;
			rd_ff <= cic_pkg::BYTE_ZERO;
			low_ff <= cic_pkg::PRIO_LOW_RST;
			sid_ff <= cic_pkg::SLAVE_ADDR_RST;
			smm_ff <= 1'b0;
			rd_isr_ff <= 1'b0;
			poll_ff <= 1'b0;
			arot_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cfg_ff <= nxt_cfg;
			irr_ff <= nxt_irr;
			isr_ff <= nxt_isr;
			imr_ff <= nxt_imr;
			last_ff <= nxt_last;
			vec_ff <= nxt_vec;
			rd_ff <= nxt_rd;
			low_ff <= nxt_low;
			sid_ff <= nxt_sid;
			smm_ff <= nxt_smm;
			rd_isr_ff <= nxt_rd_isr;
			poll_ff <= nxt_poll;
			arot_ff <= nxt_arot;
		end
	end

	// Fully nested mode lets an equal-priority line through the isr check.
	assign int_req = req_hit && (!isr_hit || (req_line != isr_line ?
		(rank_of(req_line, low_ff) < rank_of(isr_line, low_ff)) :
		cfg_ff.nested));
	assign vector = vec_ff;
	assign rd_data = rd_ff;
	assign cfg = cfg_ff;
	assign slave_id = sid_ff;

endmodule
`default_nettype wire

/* tb/cic_unit_props.sv */
// Checker for one interrupt controller unit.
`timescale 1ns/100ps
`default_nettype none
module cic_unit_props (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Unit ports
	input wire cic_pkg::cic_io_t io,
	input wire logic [7:0] irq,
	input wire logic ack,
	input wire logic int_req,
	input wire logic [7:0] vector,
	input wire logic [7:0] rd_data,
	input wire cic_pkg::cic_cfg_t cfg,
	input wire logic [2:0] slave_id
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic start;
	logic ocw;
	assign start = io.wr && !io.odd && io.data[4];
	assign ocw = io.wr && !io.odd && !io.data[4];
	property p_init_sid;
		start |=> slave_id == 3'h7;
	endproperty
	a_init_sid: assert property (p_init_sid)
		else $error("slave id not set");
	property p_init_cfg;
		start |=> cfg.need_w4 == $past(io.data[0])
			&& cfg.single == $past(io.data[1])
			&& cfg.level == $past(io.data[3]);
	endproperty
	a_init_cfg: assert property (p_init_cfg)
		else $error("first word not latched");
	property p_init_mask;
		start ##2 (io.rd && io.odd) |=> rd_data == 8'h00;
	endproperty
	a_init_mask: assert property (p_init_mask)
		else $error("mask not cleared");
	property p_ocw_mask;
		ocw ##2 (io.wr && io.odd) ##2 (io.rd && io.odd)
			|=> rd_data == $past(io.data, 3);
	endproperty
	a_ocw_mask: assert property (p_ocw_mask)
		else $error("mask write lost");
	property p_cfg_hold;
		!io.wr |=> $stable(cfg) && $stable(slave_id);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("config moved without write");
	property p_vec_hi;
		ack |=> vector[7:3] == cfg.vec_hi;
	endproperty
	a_vec_hi: assert property (p_vec_hi)
		else $error("vector high bits wrong");
	property p_vec_hold;
		!ack && !io.rd |=> $stable(vector);
	endproperty
	a_vec_hold: assert property (p_vec_hold)
		else $error("vector moved without ack");
	property p_idle;
		irq == 8'h00 && $past(irq) == 8'h00 |-> !int_req;
	endproperty
	a_idle: assert property (p_idle)
		else $error("request without input");
endmodule
bind cic_unit cic_unit_props cic_unit_props_inst (.clk, .reset, .io, .irq,
	.ack, .int_req, .vector, .rd_data, .cfg, .slave_id);
`default_nettype wire

/* tb/cic_host.sv */
// Host model: decodes I/O cycles onto the two controllers.
`timescale 1ns/100ps
`default_nettype none
module cic_host (
	// Host cycle
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] addr,
	input wire logic [7:0] data,
	// Controller side
	input wire logic [7:0] m_rd,
	input wire logic [7:0] s_rd,
	output var cic_pkg::cic_io_t m_io,
	output var cic_pkg::cic_io_t s_io,
	output logic [7:0] rd_data
);
	logic m_hit;
	logic s_hit;
	// Other addresses reach neither unit, so stray cycles are harmless.
	assign m_hit = addr[15:1] == cic_pkg::MASTER_EVEN[15:1];
	assign s_hit = addr[15:1] == cic_pkg::SLAVE_EVEN[15:1];
	assign m_io = {wr & m_hit, rd & m_hit, addr[0], data};
	assign s_io = {wr & s_hit, rd & s_hit, addr[0], data};
	assign rd_data = s_hit ? s_rd : m_rd;
endmodule
`default_nettype wire

/* tb/cascaded_interrupt_controller_tb.sv */
// Testbench for the master and slave interrupt controller pair.
`timescale 1ns/100ps
`default_nettype none
module cascaded_interrupt_controller_tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] data = 8'h00;
	logic [7:0] m_irq = 8'h00;
	logic [7:0] s_irq = 8'h00;
	logic m_ack = 1'b0;
	logic s_ack = 1'b0;
	cic_pkg::cic_io_t m_io;
	cic_pkg::cic_io_t s_io;
	cic_pkg::cic_cfg_t m_cfg;
	cic_pkg::cic_cfg_t s_cfg;
	logic [7:0] m_rd;
	logic [7:0] s_rd;
	logic [7:0] rdata;
	logic [7:0] s_vec;
	logic s_int;
	logic [2:0] s_sid;
	logic [7:0] v;
	int n_mismatch = 0;
	int total_checks = 0;
	always #2 clk = ~clk;
	cic_host cic_host_inst (.wr(wr), .rd(rd), .addr(addr), .data(data),
		.m_rd(m_rd), .s_rd(s_rd), .m_io(m_io), .s_io(s_io), .rd_data(rdata));
	cic_unit m_cic_unit_inst (.clk(clk), .reset(reset), .io(m_io),
		.irq(m_irq), .ack(m_ack), .int_req(), .vector(), .rd_data(m_rd),
		.cfg(m_cfg), .slave_id());
	cic_unit s_cic_unit_inst (.clk(clk), .reset(reset), .io(s_io),
		.irq(s_irq), .ack(s_ack), .int_req(s_int), .vector(s_vec),
		.rd_data(s_rd), .cfg(s_cfg), .slave_id(s_sid));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One host cycle per call, launched on the falling edge.
	task automatic op(input logic w, input logic r, input logic [15:0] a,
		input logic [7:0] d);
		@(negedge clk);
		wr = w;
		rd = r;
		addr = a;
		data = d;
	endtask
	task automatic wr_io(input logic [15:0] a, input logic [7:0] d);
		op(1'b1, 1'b0, a, d);
		op(1'b0, 1'b0, a, d);
	endtask
	task automatic rd_io(input logic [15:0] a, output logic [7:0] q);
		op(1'b0, 1'b1, a, 8'h00);
		op(1'b0, 1'b0, a, 8'h00);
		q = rdata;
	endtask
	task automatic init(input logic [15:0] b, input logic [7:0] w1, w2, w3,
		w4);
		wr_io(b, w1);
		wr_io(b + 16'h0001, w2);
		wr_io(b + 16'h0001, w3);
		wr_io(b + 16'h0001, w4);
	endtask
	initial begin
		repeat (4) @(negedge clk);
		reset = 1'b0;
		init(cic_pkg::MASTER_EVEN, 8'h11, 8'h08, 8'h04, 8'h01);
		init(cic_pkg::SLAVE_EVEN, 8'h19, 8'h70, 8'h02, 8'h13);
		chk({m_cfg.need_w4, m_cfg.single, m_cfg.level, m_cfg.aeoi,
			m_cfg.nested, 3'h0}, 8'h90);
		chk({s_cfg.need_w4, s_cfg.single, s_cfg.level, s_cfg.aeoi,
			s_cfg.nested, 3'h0}, 8'hA8);
		chk({3'h0, s_cfg.vec_hi}, 8'h0E);
		chk(m_cfg.cascade, 8'h04);
		chk({5'h00, s_sid}, 8'h02);
		$display("init test done");
		wr_io(cic_pkg::MASTER_ODD, 8'hFB);
		rd_io(cic_pkg::MASTER_ODD, v);
		chk(v, 8'hFB);
		wr_io(cic_pkg::MASTER_EVEN, 8'h10);
		rd_io(cic_pkg::MASTER_ODD, v);
		chk(v, 8'h00);
		wr_io(cic_pkg::MASTER_EVEN, 8'h0A);
		wr_io(cic_pkg::MASTER_ODD, 8'h5A);
		rd_io(cic_pkg::MASTER_ODD, v);
		chk(v, 8'h5A);
		$display("mask test done");
		s_irq = 8'h08;
		for (int i = 0; i < 20 && s_int !== 1'b1; i++)
			@(negedge clk);
		chk({7'h00, s_int}, 8'h01);
		s_ack = 1'b1;
		@(negedge clk);
		s_ack = 1'b0;
		@(negedge clk);
		chk(s_vec, 8'h73);
		wr_io(cic_pkg::SLAVE_EVEN, 8'h0B);
		rd_io(cic_pkg::SLAVE_EVEN, v);
		chk(v, 8'h08);
		wr_io(cic_pkg::SLAVE_EVEN, 8'h20);
		rd_io(cic_pkg::SLAVE_EVEN, v);
		chk(v, 8'h00);
		s_irq = 8'h40;
		wr_io(cic_pkg::SLAVE_EVEN, 8'h0C);
		rd_io(cic_pkg::SLAVE_EVEN, v);
		chk(v, 8'h86);
		s_irq = 8'h82;
		wr_io(cic_pkg::SLAVE_EVEN, 8'h0C);
		rd_io(cic_pkg::SLAVE_EVEN, v);
		chk(v, 8'h87);
		s_irq = 8'h02;
		@(negedge clk);
		chk({7'h00, s_int}, 8'h00);
		wr_io(cic_pkg::SLAVE_EVEN, 8'h67);
		chk({7'h00, s_int}, 8'h01);
		s_irq = 8'h00;
		$display("service test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
